// ===== core/asi_slot_map_ch5_to_ch7_map.vh
// register offsets, field positions and reset values of the channel 5..7 slot map
`ifndef ASI_SLOT_MAP_CH5_TO_CH7_MAP_VH
`define ASI_SLOT_MAP_CH5_TO_CH7_MAP_VH

`define ASM_ADDR_W 8
`define ASM_DATA_W 8

`define ASM_CH5_OFFSET 8'h0f
`define ASM_CH6_OFFSET 8'h10
`define ASM_CH7_OFFSET 8'h11

`define ASM_CH5_RESET 8'h04
`define ASM_CH6_RESET 8'h05
`define ASM_CH7_RESET 8'h06

`define ASM_RSVD_BIT 7
`define ASM_LINE_BIT 6
`define ASM_SLOT_MSB 5
`define ASM_SLOT_LSB 0
`define ASM_HALF_BIT 5
`define ASM_HALF_SLOT_MSB 4

`define ASM_RSVD_VALUE 1'b0
`define ASM_LINE_PRIMARY 1'b0
`define ASM_LINE_SECONDARY 1'b1
`define ASM_READ_UNMAPPED 8'h00

`endif

// ===== core/slot_cfg_reg.v
// one channel slot configuration register with its slot match decode
`timescale 1ns/100ps
`default_nettype none
`include "asi_slot_map_ch5_to_ch7_map.vh"

module slot_cfg_reg #(
  parameter [7:0] RESET_VAL = 8'h00
) (
  input wire clk_i,              // system clock
  input wire arst_n_i,           // async reset, active low
  input wire wr_en_i,            // write this register
  input wire [7:0] wr_data_i,    // write data
  input wire tdm_mode_i,         // 1 = tdm, 0 = i2s or left justified
  input wire [5:0] slot_num_i,   // current slot position
  input wire frame_half_i,       // 0 = left half, 1 = right half
  output wire [7:0] value_o,     // register contents, bit 7 reads zero
  output wire line_o,            // 0 primary line, 1 secondary line
  output wire hit_o              // channel owns the current slot
);

  reg line_q;
  reg [5:0] slot_q;
  wire tdm_hit;
  wire half_hit;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_q <= RESET_VAL[`ASM_LINE_BIT];
      slot_q <= RESET_VAL[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
    end else if (wr_en_i) begin
      line_q <= wr_data_i[`ASM_LINE_BIT];
      slot_q <= wr_data_i[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
    end
  end

  // the reserved bit is never stored, so a stray write of one cannot stick
  assign value_o = {`ASM_RSVD_VALUE, line_q, slot_q};
  assign line_o = line_q;

  assign tdm_hit = (slot_q == slot_num_i);
  // in half-frame formats the top index bit picks the half, the rest the slot
  assign half_hit = (slot_q[`ASM_HALF_BIT] == frame_half_i) &&
                    (slot_q[`ASM_HALF_SLOT_MSB:0] == slot_num_i[`ASM_HALF_SLOT_MSB:0]) &&
                    (slot_num_i[`ASM_HALF_BIT] == 1'b0);
  assign hit_o = tdm_mode_i ? tdm_hit : half_hit;

endmodule

`default_nettype wire

// ===== core/asi_slot_map_ch5_to_ch7.v
// slot map for recording channels 5 to 7: registers, readback and data line steering
//
// Behaviour
// - bit 7 reserved, reads zero, write zero
// - line select zero sends data to primary output
// - line select one sends data to secondary output
// - slot index is bits five down to zero
// - indices 0..31: tdm slot or left slot
// - indices 32..63: tdm slot or right slot
// - channel 5 register at 0x0f, reset 0x04
// - channel 6 register at 0x10, reset 0x05
// - channel 7 register at 0x11, reset 0x06
`timescale 1ns/100ps
`default_nettype none
`include "asi_slot_map_ch5_to_ch7_map.vh"

module asi_slot_map_ch5_to_ch7 (
  input wire REF_CLK_I,                 // 25 MHz system clock
  input wire ARST_N_I,                  // async reset, active low
  input wire [7:0] REG_ADDR_I,          // control port register offset
  input wire REG_WR_I,                  // write strobe, one cycle
  input wire REG_RD_I,                  // read strobe, one cycle
  input wire [7:0] REG_WDATA_I,         // write data
  output reg [7:0] REG_RDATA_O,         // read data, valid with REG_RVALID_O
  output reg REG_RVALID_O,              // read answer pulse
  output reg REG_ACK_O,                 // offset belonged to this block
  input wire TDM_MODE_I,                // 1 = tdm, 0 = i2s or left justified
  input wire [5:0] SLOT_NUM_I,          // current slot from framing engine
  input wire FRAME_HALF_I,              // 0 = left half-frame, 1 = right
  input wire [2:0] CH_DATA_I,           // serial bit of channels 7,6,5
  output reg PRIMARY_SERIAL_OUT_O,      // primary serial data
  output reg PRIMARY_SERIAL_OE_O,       // primary line driven
  output reg SECONDARY_SERIAL_OUT_O,    // secondary data on general pin
  output reg SECONDARY_SERIAL_OE_O,     // secondary line driven
  output reg SLOT_CONFLICT_O,           // two channels claim one slot on the same line
  output reg CHANNEL5_LINE_SELECT_O,    // channel 5 line select
  output reg [5:0] CHANNEL5_SLOT_INDEX_O, // channel 5 slot index
  output reg CHANNEL6_LINE_SELECT_O,    // channel 6 line select
  output reg [5:0] CHANNEL6_SLOT_INDEX_O, // channel 6 slot index
  output reg CHANNEL7_LINE_SELECT_O,    // channel 7 line select
  output reg [5:0] CHANNEL7_SLOT_INDEX_O  // channel 7 slot index
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire sel_ch5;
  wire sel_ch6;
  wire sel_ch7;
  wire sel_any;
  wire [2:0] wr_en;

  assign sel_ch5 = (REG_ADDR_I == `ASM_CH5_OFFSET);
  assign sel_ch6 = (REG_ADDR_I == `ASM_CH6_OFFSET);
  assign sel_ch7 = (REG_ADDR_I == `ASM_CH7_OFFSET);
  assign sel_any = sel_ch5 | sel_ch6 | sel_ch7;
  assign wr_en = {3{REG_WR_I}} & {sel_ch7, sel_ch6, sel_ch5};

  ////////////////////////////////////////////////////////////////////////////
  // channel registers

  wire [7:0] ch5_value;
  wire [7:0] ch6_value;
  wire [7:0] ch7_value;
  wire [2:0] line;
  wire [2:0] hit;

  slot_cfg_reg #(
    .RESET_VAL(`ASM_CH5_RESET)
  ) u_ch5 (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .wr_en_i(wr_en[0]),
    .wr_data_i(REG_WDATA_I),
    .tdm_mode_i(TDM_MODE_I),
    .slot_num_i(SLOT_NUM_I),
    .frame_half_i(FRAME_HALF_I),
    .value_o(ch5_value),
    .line_o(line[0]),
    .hit_o(hit[0])
  );

  slot_cfg_reg #(
    .RESET_VAL(`ASM_CH6_RESET)
  ) u_ch6 (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .wr_en_i(wr_en[1]),
    .wr_data_i(REG_WDATA_I),
    .tdm_mode_i(TDM_MODE_I),
    .slot_num_i(SLOT_NUM_I),
    .frame_half_i(FRAME_HALF_I),
    .value_o(ch6_value),
    .line_o(line[1]),
    .hit_o(hit[1])
  );

  slot_cfg_reg #(
    .RESET_VAL(`ASM_CH7_RESET)
  ) u_ch7 (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .wr_en_i(wr_en[2]),
    .wr_data_i(REG_WDATA_I),
    .tdm_mode_i(TDM_MODE_I),
    .slot_num_i(SLOT_NUM_I),
    .frame_half_i(FRAME_HALF_I),
    .value_o(ch7_value),
    .line_o(line[2]),
    .hit_o(hit[2])
  );

  ////////////////////////////////////////////////////////////////////////////
  // readback

  reg [7:0] rdata_d;

  always @* begin
    case (REG_ADDR_I)
      `ASM_CH5_OFFSET: begin
        rdata_d = ch5_value;
      end
      `ASM_CH6_OFFSET: begin
        rdata_d = ch6_value;
      end
      `ASM_CH7_OFFSET: begin
        rdata_d = ch7_value;
      end
      default: begin
        rdata_d = `ASM_READ_UNMAPPED;
      end
    endcase
  end

  // a read the same cycle as a write to that offset returns the old value
  always @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
      REG_ACK_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      REG_ACK_O <= (REG_RD_I | REG_WR_I) & sel_any;
      if (REG_RD_I) begin
        REG_RDATA_O <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line steering

  wire [2:0] prim_hit;
  wire [2:0] sec_hit;
  reg prim_bit_d;
  reg sec_bit_d;

  assign prim_hit = hit & ~line;
  assign sec_hit = hit & line;

  // overlapping channels are a software fault; the lowest channel wins so
  // the line still carries one defined sample instead of a wired-or mix
  always @* begin
    prim_bit_d = 1'b0;
    sec_bit_d = 1'b0;
    if (prim_hit[0]) begin
      prim_bit_d = CH_DATA_I[0];
    end else if (prim_hit[1]) begin
      prim_bit_d = CH_DATA_I[1];
    end else if (prim_hit[2]) begin
      prim_bit_d = CH_DATA_I[2];
    end
    if (sec_hit[0]) begin
      sec_bit_d = CH_DATA_I[0];
    end else if (sec_hit[1]) begin
      sec_bit_d = CH_DATA_I[1];
    end else if (sec_hit[2]) begin
      sec_bit_d = CH_DATA_I[2];
    end
  end

  wire conflict_d;
  assign conflict_d = (prim_hit[0] & prim_hit[1]) | (prim_hit[0] & prim_hit[2]) |
                      (prim_hit[1] & prim_hit[2]) | (sec_hit[0] & sec_hit[1]) |
                      (sec_hit[0] & sec_hit[2]) | (sec_hit[1] & sec_hit[2]);

  always @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PRIMARY_SERIAL_OUT_O <= 1'b0;
      PRIMARY_SERIAL_OE_O <= 1'b0;
      SECONDARY_SERIAL_OUT_O <= 1'b0;
      SECONDARY_SERIAL_OE_O <= 1'b0;
      SLOT_CONFLICT_O <= 1'b0;
    end else begin
      PRIMARY_SERIAL_OUT_O <= prim_bit_d;
      PRIMARY_SERIAL_OE_O <= |prim_hit;
      SECONDARY_SERIAL_OUT_O <= sec_bit_d;
      SECONDARY_SERIAL_OE_O <= |sec_hit;
      SLOT_CONFLICT_O <= conflict_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration mirror for the framing engine

  // mirror reset values come from the register reset words, so the two cannot drift
  localparam [7:0] CH5_RST = `ASM_CH5_RESET;
  localparam [7:0] CH6_RST = `ASM_CH6_RESET;
  localparam [7:0] CH7_RST = `ASM_CH7_RESET;

  always @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CHANNEL5_LINE_SELECT_O <= CH5_RST[`ASM_LINE_BIT];
      CHANNEL5_SLOT_INDEX_O <= CH5_RST[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
      CHANNEL6_LINE_SELECT_O <= CH6_RST[`ASM_LINE_BIT];
      CHANNEL6_SLOT_INDEX_O <= CH6_RST[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
      CHANNEL7_LINE_SELECT_O <= CH7_RST[`ASM_LINE_BIT];
      CHANNEL7_SLOT_INDEX_O <= CH7_RST[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
    end else begin
      CHANNEL5_LINE_SELECT_O <= ch5_value[`ASM_LINE_BIT];
      CHANNEL5_SLOT_INDEX_O <= ch5_value[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
      CHANNEL6_LINE_SELECT_O <= ch6_value[`ASM_LINE_BIT];
      CHANNEL6_SLOT_INDEX_O <= ch6_value[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
      CHANNEL7_LINE_SELECT_O <= ch7_value[`ASM_LINE_BIT];
      CHANNEL7_SLOT_INDEX_O <= ch7_value[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
    end
  end

endmodule

`default_nettype wire

// ===== test/asi_slot_map_properties.sv
// concurrent checks on the ports of the channel 5..7 slot map
`timescale 1ns/100ps
`default_nettype none
module asi_slot_map_props (
  input wire logic REF_CLK_I, ARST_N_I, REG_WR_I, REG_RD_I, REG_RVALID_O, REG_ACK_O,
  input wire logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
  input wire logic TDM_MODE_I, FRAME_HALF_I, PRIMARY_SERIAL_OE_O,
  input wire logic SECONDARY_SERIAL_OE_O, SECONDARY_SERIAL_OUT_O,
  input wire logic CHANNEL5_LINE_SELECT_O, CHANNEL6_LINE_SELECT_O, CHANNEL7_LINE_SELECT_O,
  input wire logic [5:0] SLOT_NUM_I, CHANNEL5_SLOT_INDEX_O, CHANNEL6_SLOT_INDEX_O,
  input wire logic [5:0] CHANNEL7_SLOT_INDEX_O,
  input wire logic [2:0] CH_DATA_I
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  AST_RSVD: assert property (REG_RVALID_O |-> !REG_RDATA_O[7])
    else $error("bit 7 read as one");
  AST_RD5: assert property (REG_RD_I && REG_ADDR_I == 8'h0f |=> REG_ACK_O &&
    REG_RDATA_O == {1'b0, CHANNEL5_LINE_SELECT_O, CHANNEL5_SLOT_INDEX_O}) else $error("ch5 read");
  AST_RD6: assert property (REG_RD_I && REG_ADDR_I == 8'h10 |=> REG_ACK_O &&
    REG_RDATA_O == {1'b0, CHANNEL6_LINE_SELECT_O, CHANNEL6_SLOT_INDEX_O}) else $error("ch6 read");
  AST_RD7: assert property (REG_RD_I && REG_ADDR_I == 8'h11 |=> REG_ACK_O &&
    REG_RDATA_O == {1'b0, CHANNEL7_LINE_SELECT_O, CHANNEL7_SLOT_INDEX_O}) else $error("ch7 read");
  AST_UNMAP: assert property (REG_RD_I && !(REG_ADDR_I inside {8'h0f, 8'h10, 8'h11})
    |=> REG_RVALID_O && !REG_ACK_O && REG_RDATA_O == 8'h00) else $error("unmapped read");
  AST_WR6: assert property (REG_WR_I && REG_ADDR_I == 8'h10 |=> ##1
    {1'b0, CHANNEL6_LINE_SELECT_O, CHANNEL6_SLOT_INDEX_O} == ($past(REG_WDATA_I, 2) & 8'h7f))
    else $error("ch6 write");
  // mirrors lag the register by one cycle, so a write one edge back voids the match
  AST_PRI: assert property (TDM_MODE_I && !$past(REG_WR_I) && !CHANNEL7_LINE_SELECT_O &&
    SLOT_NUM_I == CHANNEL7_SLOT_INDEX_O |=> PRIMARY_SERIAL_OE_O) else $error("primary idle");
  AST_SEC: assert property (TDM_MODE_I && !$past(REG_WR_I) && CHANNEL5_LINE_SELECT_O &&
    SLOT_NUM_I == CHANNEL5_SLOT_INDEX_O |=> SECONDARY_SERIAL_OE_O &&
    {2'b00, SECONDARY_SERIAL_OUT_O} == ($past(CH_DATA_I) & 3'h1)) else $error("secondary data");
  AST_HALF: assert property (!TDM_MODE_I && !$past(REG_WR_I) && !SLOT_NUM_I[5] &&
    {FRAME_HALF_I, SLOT_NUM_I[4:0]} == CHANNEL5_SLOT_INDEX_O && CHANNEL5_LINE_SELECT_O
    |=> SECONDARY_SERIAL_OE_O) else $error("half-frame slot");
  cover property (REG_WR_I && REG_ADDR_I == 8'h10);
  cover property (PRIMARY_SERIAL_OE_O);
  cover property (SECONDARY_SERIAL_OE_O && !TDM_MODE_I);
endmodule
`default_nettype wire

// ===== test/asi_host_rx.sv
// host receiver model: collects the bits driven on each serial line
`timescale 1ns/100ps
`default_nettype none
module asi_host_rx (
  input wire logic clk_i, arst_n_i, pri_oe_i, pri_d_i, sec_oe_i, sec_d_i,
  output logic [7:0] pri_sh_o, sec_sh_o
);
  // only driven bits count, an undriven line carries nothing for the host
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pri_sh_o <= 8'h00;
      sec_sh_o <= 8'h00;
    end else begin
      if (pri_oe_i) pri_sh_o <= {pri_sh_o[6:0], pri_d_i};
      if (sec_oe_i) sec_sh_o <= {sec_sh_o[6:0], sec_d_i};
    end
  end
endmodule
`default_nettype wire

// ===== test/asi_slot_map_ch5_to_ch7_tb.sv
// self-checking bench for the channel 5..7 slot map
`timescale 1ns/100ps
`default_nettype none
module asi_slot_map_ch5_to_ch7_tb;
  logic REF_CLK_I = 1'b0;
  logic ARST_N_I, REG_WR_I, REG_RD_I, TDM_MODE_I, FRAME_HALF_I, REG_RVALID_O, REG_ACK_O;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, pri_sh, sec_sh;
  logic [5:0] SLOT_NUM_I, CHANNEL5_SLOT_INDEX_O, CHANNEL6_SLOT_INDEX_O, CHANNEL7_SLOT_INDEX_O;
  logic [2:0] CH_DATA_I;
  logic PRIMARY_SERIAL_OUT_O, PRIMARY_SERIAL_OE_O, SECONDARY_SERIAL_OUT_O;
  logic SECONDARY_SERIAL_OE_O, SLOT_CONFLICT_O, CHANNEL5_LINE_SELECT_O;
  logic CHANNEL6_LINE_SELECT_O, CHANNEL7_LINE_SELECT_O;
  int err_total = 0;
  int check_count = 0;
  // row: tdm, half, slot, data 7..5, then primary oe/out, secondary oe/out
  logic [14:0] row;
  // rows 3 and 4 hit with the owning channel at zero, so a stuck-high data line shows
  function automatic logic [14:0] steer_row(input int i);
    case (i)
      0: steer_row = 15'b1_0_111111_001_0011;
      1: steer_row = 15'b1_0_000110_100_1100;
      2: steer_row = 15'b1_0_000111_010_0011;
      3: steer_row = 15'b0_1_011111_110_0010;
      4: steer_row = 15'b0_0_000110_011_1000;
      5: steer_row = 15'b0_1_000110_100_0000;
      6: steer_row = 15'b0_0_011111_001_0000;
      default: steer_row = 15'b1_0_000101_111_0000;
    endcase
  endfunction
  always #20 REF_CLK_I = ~REF_CLK_I;
  asi_slot_map_ch5_to_ch7 i_asi_slot_map_ch5_to_ch7 (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
    .REG_ACK_O(REG_ACK_O), .TDM_MODE_I(TDM_MODE_I), .SLOT_NUM_I(SLOT_NUM_I),
    .FRAME_HALF_I(FRAME_HALF_I), .CH_DATA_I(CH_DATA_I),
    .PRIMARY_SERIAL_OUT_O(PRIMARY_SERIAL_OUT_O), .PRIMARY_SERIAL_OE_O(PRIMARY_SERIAL_OE_O),
    .SECONDARY_SERIAL_OUT_O(SECONDARY_SERIAL_OUT_O),
    .SECONDARY_SERIAL_OE_O(SECONDARY_SERIAL_OE_O), .SLOT_CONFLICT_O(SLOT_CONFLICT_O),
    .CHANNEL5_LINE_SELECT_O(CHANNEL5_LINE_SELECT_O),
    .CHANNEL5_SLOT_INDEX_O(CHANNEL5_SLOT_INDEX_O),
    .CHANNEL6_LINE_SELECT_O(CHANNEL6_LINE_SELECT_O),
    .CHANNEL6_SLOT_INDEX_O(CHANNEL6_SLOT_INDEX_O),
    .CHANNEL7_LINE_SELECT_O(CHANNEL7_LINE_SELECT_O),
    .CHANNEL7_SLOT_INDEX_O(CHANNEL7_SLOT_INDEX_O));
  asi_host_rx i_asi_host_rx (.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I),
    .pri_oe_i(PRIMARY_SERIAL_OE_O), .pri_d_i(PRIMARY_SERIAL_OUT_O), .sec_oe_i(SECONDARY_SERIAL_OE_O),
    .sec_d_i(SECONDARY_SERIAL_OUT_O), .pri_sh_o(pri_sh), .sec_sh_o(sec_sh));
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic ack);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'b0;
    #1;
    chk({7'h00, REG_ACK_O}, {7'h00, ack}, "write ack");
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic ack);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'b0;
    #1;
    chk({6'h00, REG_RVALID_O, REG_ACK_O}, {6'h00, 1'b1, ack}, "read answer");
    chk(REG_RDATA_O, exp, "read data");
  endtask
  task t_reset;
    @(posedge REF_CLK_I);
    ARST_N_I <= 1'b0;
    repeat (12) @(posedge REF_CLK_I);
    chk({1'b0, CHANNEL5_LINE_SELECT_O, CHANNEL5_SLOT_INDEX_O}, 8'h04, "ch5 mirror");
    ARST_N_I <= 1'b1;
    rd(8'h0f, 8'h04, 1'b1);
    rd(8'h10, 8'h05, 1'b1);
    rd(8'h11, 8'h06, 1'b1);
    $display("reset test done");
  endtask
  task t_regs;
    wr(8'h0f, 8'h7f, 1'b1);
    rd(8'h0f, 8'h7f, 1'b1);
    wr(8'h10, 8'h47, 1'b1);
    rd(8'h10, 8'h47, 1'b1);
    chk({1'b0, CHANNEL6_LINE_SELECT_O, CHANNEL6_SLOT_INDEX_O}, 8'h47, "ch6 mirror");
    wr(8'h12, 8'h3c, 1'b0);
    rd(8'h12, 8'h00, 1'b0);
    rd(8'h0e, 8'h00, 1'b0);
    rd(8'h11, 8'h06, 1'b1);
    $display("register test done");
  endtask
  // slots 63, 7 and 6 are kept apart so no two channels share a line and slot
  task t_steer;
    for (int i = 0; i < 8; i++) begin
      @(posedge REF_CLK_I);
      row = steer_row(i);
      {TDM_MODE_I, FRAME_HALF_I, SLOT_NUM_I, CH_DATA_I} <= row[14:4];
      @(posedge REF_CLK_I);
      #1;
      chk({3'h0, SLOT_CONFLICT_O, PRIMARY_SERIAL_OE_O, PRIMARY_SERIAL_OUT_O,
        SECONDARY_SERIAL_OE_O, SECONDARY_SERIAL_OUT_O}, {4'h0, row[3:0]}, "steering");
    end
    // each row stands two cycles, so the host shifts every driven bit twice
    chk(pri_sh, 8'h0c, "host primary bits");
    chk(sec_sh, 8'h3c, "host secondary bits");
    $display("steering test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    ARST_N_I = 1'b0;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    REG_ADDR_I = 8'h00;
    REG_WDATA_I = 8'h00;
    TDM_MODE_I = 1'b0;
    FRAME_HALF_I = 1'b0;
    SLOT_NUM_I = 6'h00;
    CH_DATA_I = 3'h0;
    t_reset;
    t_regs;
    t_steer;
    t_reset;
    end_sim;
  end
endmodule
bind asi_slot_map_ch5_to_ch7 asi_slot_map_props i_asi_slot_map_props (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RVALID_O(REG_RVALID_O),
  .REG_ACK_O(REG_ACK_O), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O), .TDM_MODE_I(TDM_MODE_I), .FRAME_HALF_I(FRAME_HALF_I),
  .PRIMARY_SERIAL_OE_O(PRIMARY_SERIAL_OE_O), .SECONDARY_SERIAL_OE_O(SECONDARY_SERIAL_OE_O),
  .SECONDARY_SERIAL_OUT_O(SECONDARY_SERIAL_OUT_O),
  .CHANNEL5_LINE_SELECT_O(CHANNEL5_LINE_SELECT_O),
  .CHANNEL6_LINE_SELECT_O(CHANNEL6_LINE_SELECT_O),
  .CHANNEL7_LINE_SELECT_O(CHANNEL7_LINE_SELECT_O), .SLOT_NUM_I(SLOT_NUM_I),
  .CHANNEL5_SLOT_INDEX_O(CHANNEL5_SLOT_INDEX_O), .CHANNEL6_SLOT_INDEX_O(CHANNEL6_SLOT_INDEX_O),
  .CHANNEL7_SLOT_INDEX_O(CHANNEL7_SLOT_INDEX_O), .CH_DATA_I(CH_DATA_I));
`default_nettype wire
